// ---- flpd_pkg.sv ----
// Package of entry field positions, encodings and APB map for the decoder.
package flpd_pkg;

    // ------------------------------------------------------------------
    // Entry field positions
    // ------------------------------------------------------------------
    localparam int ENT_W           = 64;
    localparam int BIT_PRESENT     = 0;
    localparam int BIT_WRITE_OK    = 1;
    localparam int BIT_USER_OK     = 2;
    localparam int BIT_WT          = 3;
    localparam int BIT_CD          = 4;
    localparam int BIT_USED        = 5;
    localparam int BIT_LARGE_LEAF  = 7;
    localparam int BIT_EXT_USED    = 10;
    localparam int BIT_ADDR_LO     = 12;
    localparam int BIT_RSV_HI      = 51;
    localparam int BIT_EXEC_DIS    = 63;
    localparam int HOST_AW_DEFAULT = 48;

    // ------------------------------------------------------------------
    // APB register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL     = 8'h00;
    localparam logic [7:0] OFF_ENT_LO   = 8'h04;
    localparam logic [7:0] OFF_ENT_HI   = 8'h08;
    localparam logic [7:0] OFF_STATUS   = 8'h0c;
    localparam logic [7:0] OFF_BASE_LO  = 8'h10;
    localparam logic [7:0] OFF_BASE_HI  = 8'h14;
    localparam logic [7:0] OFF_UPD_LO   = 8'h18;
    localparam logic [7:0] OFF_CAP      = 8'h1c;

    // CTRL bits.
    localparam int C_EXT_EN   = 0;
    localparam int C_EXT_SUP  = 1;
    localparam int C_NX_EN    = 2;
    localparam int C_WP_EN    = 3;
    localparam int C_NEST_EN  = 4;
    localparam int C_COHERENT = 5;
    localparam int C_USER     = 6;
    localparam int C_WRITE    = 7;
    localparam int C_EXEC     = 8;
    localparam int C_SECOND   = 9;
    localparam int CTRL_W     = 10;

    // STATUS bits.
    localparam int S_OK       = 0;
    localparam int S_NOT_PRES = 1;
    localparam int S_MALFORM  = 2;
    localparam int S_USER_DEN = 3;
    localparam int S_WR_DEN   = 4;
    localparam int S_EX_DEN   = 5;
    localparam int S_GPA      = 6;
    localparam int S_MT_LO    = 7;
    localparam int S_LEAF     = 9;
    localparam int S_EXT_SET  = 10;
    localparam int S_BUSY     = 11;

    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    localparam logic [31:0] ONE_GIG_SUPPORT_DEF = 32'h0000_0001;
    localparam logic [1:0]  MT_DEFAULT = 2'h0;

    // Decoder progress.
    typedef enum logic [1:0] {
        FLPD_IDLE   = 2'b00,
        FLPD_DECIDE = 2'b01,
        FLPD_DONE   = 2'b10
    } flpd_state_e;

endpackage : flpd_pkg

// ---- flpd_entry_decode.sv ----
// Top-level paging entry decoder with APB register access.
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none

// How it works
// RULE1 - With extended-used enabled, set entry bit 10 on every access. The code sets it only for present entries that are not malformed.
// RULE2 - Ignore bit 10 without support or without the space's enable.
// RULE3 - Deny execute when bit 63 and no-execute enable are both one.
// RULE4 - Bits host width minus one down to 12 form the next-table base.
// RULE5 - Nested enable marks the table address as guest-physical.
// RULE6 - Bit 5 is the used bit, set when the entry translates.
// RULE7 - Only coherent requesters take memory type from bits 4 and 3.
// RULE8 - Bit 2 clear refuses user-privilege requests.
// RULE9 - Bit 1 clear denies user writes, and supervisor writes if protected.
// RULE10 - Bit 0 must be one for the entry to be usable.
// RULE11 - A capability field reports one-gigabyte leaf support.
// RULE12 - A second-level entry is a gigabyte leaf only with bit 7 set.
// RULE13 - Nonzero reserved bits mark the entry malformed and fail it.
module flpd_entry_decode #(
    parameter int HOST_AW = flpd_pkg::HOST_AW_DEFAULT,
    parameter logic [31:0] ONE_GIG_SUPPORT = flpd_pkg::ONE_GIG_SUPPORT_DEF
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr
);
    import flpd_pkg::*;

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [CTRL_W-1:0] ctrl_q;
    logic [ENT_W-1:0]  entry_q;
    logic [31:0]       status_q;
    logic [ENT_W-1:0]  base_q;
    logic [ENT_W-1:0]  upd_q;
    flpd_state_e       state_q;
    logic              start_q;
    logic [31:0]       rd_word;
    logic [31:0]       prdata_q;

    logic wr_en;
    logic rd_en;
    logic addr_ok;

    // Register offsets recognised by the slave.
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == OFF_CTRL) || (a == OFF_ENT_LO) ||
                 (a == OFF_ENT_HI) || (a == OFF_STATUS) ||
                 (a == OFF_BASE_LO) || (a == OFF_BASE_HI) ||
                 (a == OFF_UPD_LO) || (a == OFF_CAP);
    endfunction : mapped

    // Zero-wait slave; unmapped addresses answer with an error.
    // Reads are picked up in the setup phase, writes in the access phase.
    assign addr_ok = mapped(paddr);
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !addr_ok;
    assign wr_en   = psel && penable && pwrite && addr_ok;
    assign rd_en   = psel && !penable && !pwrite;

    // ------------------------------------------------------------------
    // Combinational decode of the held entry
    // ------------------------------------------------------------------
    logic [ENT_W-1:0] rsv_mask;
    logic [ENT_W-1:0] addr_mask;
    logic             present;
    logic             malformed;
    logic             user_den;
    logic             wr_den;
    logic             ex_den;
    logic             ext_active;
    logic             leaf;
    logic [1:0]       mem_type;
    logic             pass;

    // Masks follow the host address width parameter.
    always_comb begin
        rsv_mask  = '0;
        addr_mask = '0;
        for (int i = 0; i < ENT_W; i++) begin
            if (i >= HOST_AW && i <= BIT_RSV_HI) begin
                rsv_mask[i] = 1'b1;
            end
            if (i >= BIT_ADDR_LO && i < HOST_AW) begin
                addr_mask[i] = 1'b1;
            end
        end
    end

    always_comb begin
        // RULE10 present check
        present = entry_q[BIT_PRESENT];
        // RULE13 reserved bits, bit 7 reserved only at the top level
        malformed = |(entry_q & rsv_mask) ||
                    (!ctrl_q[C_SECOND] && entry_q[BIT_LARGE_LEAF]);
        // RULE12 gigabyte leaf only for second-level entries
        leaf = ctrl_q[C_SECOND] && entry_q[BIT_LARGE_LEAF];
        // RULE8 user privilege check
        user_den = ctrl_q[C_USER] && !entry_q[BIT_USER_OK];
        // RULE9 write permission check
        wr_den = ctrl_q[C_WRITE] && !entry_q[BIT_WRITE_OK] &&
                 (ctrl_q[C_USER] || ctrl_q[C_WP_EN]);
        // RULE3 execute disable
        ex_den = ctrl_q[C_EXEC] && ctrl_q[C_NX_EN] &&
                 entry_q[BIT_EXEC_DIS];
        // RULE2 extended-used needs support and enable
        ext_active = ctrl_q[C_EXT_SUP] && ctrl_q[C_EXT_EN];
        // RULE7 memory type only for coherent requesters
        mem_type = ctrl_q[C_COHERENT] ?
                   {entry_q[BIT_CD], entry_q[BIT_WT]} : MT_DEFAULT;
        pass = present && !malformed && !user_den && !wr_den && !ex_den;
    end

    // ------------------------------------------------------------------
    // Decode sequencing
    // ------------------------------------------------------------------
    // A launch that lands in DONE goes straight on, so a quick relaunch
    // of the next entry is not lost.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= FLPD_IDLE;
        end else begin
            case (state_q)
                FLPD_IDLE:   state_q <= start_q ? FLPD_DECIDE : FLPD_IDLE;
                FLPD_DECIDE: state_q <= FLPD_DONE;
                FLPD_DONE:   state_q <= start_q ? FLPD_DECIDE : FLPD_IDLE;
                default:     state_q <= FLPD_IDLE;
            endcase
        end
    end

    // Writing the high entry word launches a decode.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_q <= 1'b0;
        end else begin
            start_q <= wr_en && (paddr == OFF_ENT_HI);
        end
    end

    // Control register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= '0;
        end else if (wr_en && paddr == OFF_CTRL) begin
            ctrl_q <= pwdata[CTRL_W-1:0];
        end
    end

    // Entry image written by software.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            entry_q <= '0;
        end else if (wr_en && paddr == OFF_ENT_LO) begin
            entry_q[31:0] <= pwdata;
        end else if (wr_en && paddr == OFF_ENT_HI) begin
            entry_q[63:32] <= pwdata;
        end
    end

    // Result of a decode, latched when it completes.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= RESET_WORD;
            base_q   <= '0;
            upd_q    <= '0;
        end else if (state_q == FLPD_DECIDE) begin
            status_q              <= RESET_WORD;
            status_q[S_OK]        <= pass;
            status_q[S_NOT_PRES]  <= !present;
            status_q[S_MALFORM]   <= malformed;
            status_q[S_USER_DEN]  <= user_den;
            status_q[S_WR_DEN]    <= wr_den;
            status_q[S_EX_DEN]    <= ex_den;
            // RULE5 guest-physical marking
            status_q[S_GPA]       <= ctrl_q[C_NEST_EN];
            status_q[S_MT_LO+1 -: 2] <= mem_type;
            status_q[S_LEAF]      <= leaf;
            status_q[S_EXT_SET]   <= pass && ext_active;
            // RULE4 next-table base from the address field
            base_q <= entry_q & addr_mask;
            upd_q  <= entry_q;
            if (present && !malformed) begin
                // RULE6 used bit recorded on access
                upd_q[BIT_USED] <= 1'b1;
                // RULE1 extended-used bit set when enabled
                if (ext_active) begin
                    upd_q[BIT_EXT_USED] <= 1'b1;
                end
            end
        end
    end

    // Read word selected by the address; unmapped places read as zero.
    always_comb begin
        rd_word = RESET_WORD;
        case (paddr)
            OFF_CTRL:    rd_word[CTRL_W-1:0] = ctrl_q;
            OFF_ENT_LO:  rd_word = entry_q[31:0];
            OFF_ENT_HI:  rd_word = entry_q[63:32];
            OFF_STATUS:  begin
                rd_word = status_q;
                rd_word[S_BUSY] = (state_q != FLPD_IDLE) || start_q;
            end
            OFF_BASE_LO: rd_word = base_q[31:0];
            OFF_BASE_HI: rd_word = base_q[63:32];
            OFF_UPD_LO:  rd_word = upd_q[31:0];
            // RULE11 gigabyte leaf capability
            OFF_CAP:     rd_word = ONE_GIG_SUPPORT;
            default:     rd_word = RESET_WORD;
        endcase
    end

    // Read data is captured at the end of the setup phase, so the answer
    // comes from a flop and still needs no wait state. The price is that
    // the status word shows the decoder as it was one cycle earlier.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= RESET_WORD;
        end else if (rd_en) begin
            prdata_q <= rd_word;
        end else if (!(psel && penable)) begin
            prdata_q <= RESET_WORD;
        end
    end

    // The bus sees the captured word directly.
    assign prdata = prdata_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    ext_used_a: assert property ( // RULE1
        state_q == FLPD_DECIDE && ext_active && present && !malformed
        |=> upd_q[BIT_EXT_USED]) else $error("ext used bit not set");
    ext_ignore_a: assert property ( // RULE2
        state_q == FLPD_DECIDE && !ext_active
        |=> upd_q[BIT_EXT_USED] == $past(entry_q[BIT_EXT_USED]))
        else $error("ext used bit changed while ignored");
    exec_deny_a: assert property ( // RULE3
        state_q == FLPD_DECIDE && ctrl_q[C_EXEC] && ctrl_q[C_NX_EN] &&
        entry_q[BIT_EXEC_DIS] |=> status_q[S_EX_DEN] && !status_q[S_OK])
        else $error("execute not denied");
    base_addr_a: assert property ( // RULE4
        state_q == FLPD_DECIDE |=> base_q[BIT_ADDR_LO-1:0] == '0)
        else $error("base not aligned");
    nested_gpa_a: assert property ( // RULE5
        state_q == FLPD_DECIDE
        |=> status_q[S_GPA] == $past(ctrl_q[C_NEST_EN]))
        else $error("guest address flag wrong");
    used_bit_a: assert property ( // RULE6
        state_q == FLPD_DECIDE && present && !malformed
        |=> upd_q[BIT_USED]) else $error("used bit not set");
    mem_type_a: assert property ( // RULE7
        state_q == FLPD_DECIDE && !ctrl_q[C_COHERENT]
        |=> status_q[S_MT_LO+1 -: 2] == MT_DEFAULT)
        else $error("memory type leaked to noncoherent");
    user_deny_a: assert property ( // RULE8
        state_q == FLPD_DECIDE && ctrl_q[C_USER] && !entry_q[BIT_USER_OK]
        |=> !status_q[S_OK]) else $error("user access granted");
    write_deny_a: assert property ( // RULE9
        state_q == FLPD_DECIDE && ctrl_q[C_WRITE] && ctrl_q[C_WP_EN] &&
        !entry_q[BIT_WRITE_OK] |=> status_q[S_WR_DEN])
        else $error("write not denied");
    present_chk_a: assert property ( // RULE10
        state_q == FLPD_DECIDE && !present |=> !status_q[S_OK])
        else $error("absent entry passed");
    leaf_only_a: assert property ( // RULE12
        state_q == FLPD_DECIDE && !ctrl_q[C_SECOND] |=> !status_q[S_LEAF])
        else $error("top entry marked leaf");
    malformed_a: assert property ( // RULE13
        state_q == FLPD_DECIDE && |(entry_q & rsv_mask)
        |=> status_q[S_MALFORM] && !status_q[S_OK])
        else $error("reserved bits accepted");
    decode_time_a: assert property (
        start_q |=> state_q == FLPD_DECIDE ##1 state_q == FLPD_DONE)
        else $error("decode timing wrong");

    // Permission and field checks beyond the basic ones above.
    write_user_a: assert property ( // RULE9
        state_q == FLPD_DECIDE && ctrl_q[C_WRITE] && ctrl_q[C_USER] &&
        !entry_q[BIT_WRITE_OK] |=> status_q[S_WR_DEN] && !status_q[S_OK])
        else $error("user write not denied");
    sup_write_a: assert property ( // RULE9
        state_q == FLPD_DECIDE && !ctrl_q[C_USER] && !ctrl_q[C_WP_EN]
        |=> !status_q[S_WR_DEN]) else $error("supervisor write denied");
    user_flag_a: assert property ( // RULE8
        state_q == FLPD_DECIDE && ctrl_q[C_USER] && !entry_q[BIT_USER_OK]
        |=> status_q[S_USER_DEN]) else $error("user denial not flagged");
    absent_flag_a: assert property ( // RULE10
        state_q == FLPD_DECIDE && !present |=> status_q[S_NOT_PRES])
        else $error("absent entry not flagged");
    mem_type_coh_a: assert property ( // RULE7
        state_q == FLPD_DECIDE && ctrl_q[C_COHERENT]
        |=> status_q[S_MT_LO+1] == $past(entry_q[BIT_CD]) &&
            status_q[S_MT_LO] == $past(entry_q[BIT_WT]))
        else $error("memory type not taken from entry");
    base_val_a: assert property ( // RULE4
        state_q == FLPD_DECIDE |=> base_q[HOST_AW-1:BIT_ADDR_LO] ==
            $past(entry_q[HOST_AW-1:BIT_ADDR_LO]))
        else $error("base address field wrong");

    // Bus-side checks.
    refused_wr_a: assert property (
        pslverr && pwrite |=> ctrl_q == $past(ctrl_q))
        else $error("refused write landed");
    idle_data_a: assert property (
        !psel |=> prdata == RESET_WORD)
        else $error("read data left standing");

    pass_c:   cover property (state_q == FLPD_DECIDE && pass);
    fail_c:   cover property (state_q == FLPD_DECIDE && malformed);
    extset_c: cover property (state_q == FLPD_DECIDE && pass && ext_active);
    leaf_c:   cover property (state_q == FLPD_DECIDE && leaf);
    relaunch_c: cover property (state_q == FLPD_DONE && start_q);

endmodule : flpd_entry_decode

`default_nettype wire

// ---- flpd_host_model.sv ----
// Register-side host model that issues APB transfers to the entry decoder.
`timescale 1ns/1ps
`default_nettype none

module flpd_host_model (
    // Clock
    input  wire logic        pclk,
    // APB master side
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [7:0]  paddr,
    output logic      [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);

    // Idle bus from time zero so no stray request reaches the slave.
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0000_0000;
    end

    // ------------------------------------------------------------------
    // One transfer
    // ------------------------------------------------------------------
    // The request is held until pready is seen at an edge; the answer is
    // taken at that same edge, so a slow slave is handled as well.
    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [31:0] wd, output logic [31:0] rd,
                        output logic err);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

endmodule : flpd_host_model

`default_nettype wire

// ---- flpd_entry_decode_bench.sv ----
// Self-checking bench for the paging entry decoder over APB.
`timescale 1ns/1ps
`default_nettype none

module flpd_entry_decode_bench;
    import flpd_pkg::*;

    // ------------------------------------------------------------------
    // Wiring and bookkeeping
    // ------------------------------------------------------------------
    localparam logic [31:0] CAP_VALUE = 32'h0000_0001;
    typedef struct {
        logic [31:0] ctrl, hi, lo, mask, exp, upd;
    } flpd_case_s;

    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    int          miscompares;
    int          samples_checked;
    int          cycle_count;
    flpd_case_s  cases [20];
    logic [31:0] rd;
    logic        err;

    flpd_entry_decode #(.HOST_AW(48), .ONE_GIG_SUPPORT(CAP_VALUE)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr)
    );

    flpd_host_model i_host (
        .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr)
    );

    // Free-running clock at 200 MHz.
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // A hang anywhere ends the run through the same closing report.
    always @(posedge pclk) begin
        cycle_count++;
        if (cycle_count == 5000) begin
            miscompares++;
            complete_run();
        end
    end

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : complete_run

    // Program one entry, wait out the decode and compare the outcome.
    // Only the busy bit, the status bits in the mask and, when upd is nonzero, the updated entry word are judged; other status bits are open.
    task automatic run_case(input flpd_case_s c);
        int n;
        i_host.xfer(1'b1, OFF_CTRL, c.ctrl, rd, err);
        i_host.xfer(1'b1, OFF_ENT_LO, c.lo, rd, err);
        i_host.xfer(1'b1, OFF_ENT_HI, c.hi, rd, err);
        i_host.xfer(1'b0, OFF_STATUS, 32'h0, rd, err);
        check("busy", 32'h0000_0800, rd & 32'h0000_0800);
        for (n = 0; n < 20 && rd[S_BUSY] !== 1'b0; n++)
            i_host.xfer(1'b0, OFF_STATUS, 32'h0, rd, err);
        check("busy clear", 32'h0, rd & 32'h0000_0800);
        check("status", c.exp, rd & c.mask);
        if (c.upd != 32'h0) begin
            i_host.xfer(1'b0, OFF_UPD_LO, 32'h0, rd, err);
            check("updated entry", c.upd, rd);
        end
    endtask : run_case

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        miscompares     = 0;
        samples_checked = 0;
        cycle_count     = 0;
        presetn         = 1'b0;
        // Software marks entries present where a usable table is meant.
        // present, except case 1
        cases[0]  = '{0, 0, 32'h1003, 32'h7f, 32'h001, 32'h1023};
        cases[1]  = '{0, 0, 32'h1002, 32'h3, 32'h2, 0};
        cases[2]  = '{0, 0, 32'h1081, 32'h5, 32'h4, 0};
        cases[3]  = '{0, 32'h10000, 32'h1001, 32'h5, 32'h4, 0};
        cases[4]  = '{32'h40, 0, 32'h1003, 32'h9, 32'h8, 0};
        cases[5]  = '{32'h40, 0, 32'h1007, 32'h9, 32'h1, 0};
        cases[6]  = '{32'h80, 0, 32'h1001, 32'h11, 32'h1, 0};
        cases[7]  = '{32'h88, 0, 32'h1001, 32'h11, 32'h10, 0};
        cases[8]  = '{32'hc0, 0, 32'h1005, 32'h11, 32'h10, 0};
        cases[9]  = '{32'h104, 32'h8000_0000, 32'h1001, 32'h21, 32'h20,
                      0};
        cases[10] = '{32'h100, 32'h8000_0000, 32'h1001, 32'h21, 32'h1,
                      0};
        cases[11] = '{32'h10, 0, 32'h1001, 32'h40, 32'h40, 0};
        cases[12] = '{32'h20, 0, 32'h1019, 32'h180, 32'h180, 0};
        cases[13] = '{0, 0, 32'h1019, 32'h180, 0, 0};
        cases[14] = '{32'h3, 0, 32'h1001, 32'h400, 32'h400,
                      32'h1421};
        cases[15] = '{32'h1, 0, 32'h1001, 32'h400, 0, 32'h1021};
        cases[16] = '{32'h2, 0, 32'h1001, 32'h400, 0, 32'h1021};
        cases[17] = '{32'h200, 0, 32'h1081, 32'h204, 32'h200, 0};
        cases[18] = '{32'h200, 0, 32'h1001, 32'h200, 0, 0};
        cases[19] = '{0, 32'habcd, 32'h1234_5001, 32'h1, 32'h1, 0};
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        // Registers come out of reset cleared.
        i_host.xfer(1'b0, OFF_CTRL, 32'h0, rd, err);
        check("ctrl reset", RESET_WORD, rd);
        i_host.xfer(1'b0, OFF_STATUS, 32'h0, rd, err);
        check("status reset", RESET_WORD, rd);
        i_host.xfer(1'b0, OFF_CAP, 32'h0, rd, err);
        check("capability", CAP_VALUE, rd);
        check("mapped error", 32'h0, {31'h0, err});
        check("ready", 32'h1, {31'h0, pready});
        // An unmapped place answers with an error and no data.
        i_host.xfer(1'b0, 8'h20, 32'h0, rd, err);
        check("unmapped data", 32'h0, rd);
        check("unmapped error", 32'h1, {31'h0, err});
        // A refused write must not land anywhere.
        i_host.xfer(1'b1, 8'h20, 32'h0000_03ff, rd, err);
        check("unmapped write error", 32'h1, {31'h0, err});
        i_host.xfer(1'b0, OFF_CTRL, 32'h0, rd, err);
        check("ctrl untouched", RESET_WORD, rd);
        foreach (cases[i]) run_case(cases[i]);
        i_host.xfer(1'b0, OFF_BASE_LO, 32'h0, rd, err);
        check("base low", 32'h1234_5000, rd);
        i_host.xfer(1'b0, OFF_BASE_HI, 32'h0, rd, err);
        check("base high", 32'h0000_abcd, rd);
        complete_run();
    end

endmodule : flpd_entry_decode_bench

`default_nettype wire
